/* rtl/tccg_pkg.sv */
/*
 * Constants of the tape check generator: word layout, register map,
 * field positions, reset values and timing counts.
 * Assumes a 100 MHz system clock.
 */
package tccg_pkg;

	////////////////////////////////////////////////////////////////////////
	// Character layout: bits 0..7 data, bit 8 parity
	localparam int WORD_W = 9;
	localparam int PARITY_IDX = 8;
	localparam int FEEDBACK_TAP_IDX = 7;
	localparam logic [8:0] CHECK_TRUE_MASK = 9'h014;

	////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int STROBE_DELAY_US = 5;
	localparam int GAP_DELAY_US = 10;
	localparam int GAP_PULSE_US = 10;
	localparam int STROBE_DELAY_CYCLES =
		(STROBE_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GAP_DELAY_CYCLES =
		(GAP_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GAP_PULSE_CYCLES =
		(GAP_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////
	// Register map (byte addresses)
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam logic [7:0] COUNT_OFFSET = 8'h08;
	localparam int CTRL_NINE_BIT = 0;
	localparam int CTRL_CLEAR_BIT = 1;
	localparam logic CTRL_NINE_RESET = 1'b1;
	localparam int STATUS_ROUTE_BIT = 9;
	localparam int STATUS_GAP_BIT = 10;
	localparam int STATUS_STALL_BIT = 11;

	////////////////////////////////////////////////////////////////////////
	// Gap sequence, Gray coded along its path
	typedef enum logic [1:0] {
		GAP_IDLE = 2'h0,
		GAP_DELAY = 2'h1,
		GAP_PULSE = 2'h3,
		GAP_ROUTE = 2'h2
	} tccg_gap_type;

endpackage : tccg_pkg

/* rtl/tccg_stream_if.sv */
/*
 * Word stream between the generator core and its output buffer.
 * Assumes both ends share one clock; a word moves when valid and ready.
 */
interface tccg_stream_if #(
	parameter int WIDTH = 9
);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;

	modport source (
		output valid,
		output data,
		input ready
	);

	modport sink (
		input valid,
		input data,
		output ready
	);
endinterface : tccg_stream_if

/* rtl/tccg_sync.sv */
/*
 * Pin synchroniser: four flip-flops per bit, a new level is taken
 * once the second and third agree.
 * Assumes inputs asynchronous to clk.
 */
module tccg_sync #(
	parameter int WIDTH = 12,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Pins and filtered levels
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] level
);
	for (genvar b = 0; b < WIDTH; b++) begin : gen_bit
		logic s1;
		logic s2;
		logic s3;
		// The first stage feeds only the second
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				s1 <= INIT[b];
				s2 <= INIT[b];
				s3 <= INIT[b];
				level[b] <= INIT[b];
			end else begin
				s1 <= pinIn[b];
				s2 <= s1;
				s3 <= s2;
				if (s2 == s3) begin
					level[b] <= s3;
				end
			end
		end
	end
endmodule : tccg_sync

/* rtl/tccg_skid.sv */
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes the drain side may hold ready low for any time.
 */
module tccg_skid #(
	parameter int WIDTH = 9
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Fill side
	tccg_stream_if.sink inPort,
	// Drain side
	output logic outValid,
	output logic [WIDTH-1:0] outData,
	input wire logic outReady
);
	logic skidValid;
	logic [WIDTH-1:0] skidData;
	logic inFire;

	// Ready is a flop so the source never sees a combinational loop
	assign inFire = inPort.valid & inPort.ready;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			outValid <= 1'b0;
			outData <= '0;
			skidValid <= 1'b0;
			skidData <= '0;
			inPort.ready <= 1'b0;
		end else begin
			if (!outValid || outReady) begin
				if (skidValid) begin
					outValid <= 1'b1;
					outData <= skidData;
					skidValid <= inFire;
					skidData <= inPort.data;
				end else begin
					outValid <= inFire;
					outData <= inFire ? inPort.data : outData;
				end
			end else if (inFire) begin
				skidValid <= 1'b1;
				skidData <= inPort.data;
			end
			inPort.ready <= !(skidValid || (outValid && !outReady && inFire));
		end
	end
endmodule : tccg_skid

/* rtl/tccg_top.sv */
/*
 * Cyclic check character generator for nine-track tape writing, with
 * an APB register slave, pin synchronisers and a two-entry output buffer.
 * Assumes 100 MHz clk, pins asynchronous, buffer drain may stall.
 */
module tccg_top
	import tccg_pkg::*;
#(
	parameter int STROBE_DLY_CYC = STROBE_DELAY_CYCLES,
	parameter int GAP_DLY_CYC = GAP_DELAY_CYCLES,
	parameter int GAP_PULSE_CYC = GAP_PULSE_CYCLES,
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Write data pins
	input wire logic [WORD_W-1:0] writeData_n,
	input wire logic writeStrobe,
	input wire logic checkEnable,
	input wire logic checkCharEnable_n,
	// Toward the write buffer
	output logic bufValid,
	output logic [WORD_W-1:0] bufData_n,
	input wire logic bufReady,
	output logic write_check_pulse_n,
	output logic checkRouted
);

	localparam int SDW = $clog2(STROBE_DLY_CYC + 1);
	localparam int GDW = $clog2(GAP_DLY_CYC + GAP_PULSE_CYC + 1);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic [WORD_W+2:0] pinLevel;
	logic [WORD_W-1:0] dataIn_n;
	logic strobeLevel;
	logic enableLevel;
	logic clearLevel_n;

	tccg_sync #(
		.WIDTH(WORD_W + 3),
		.INIT({1'b1, 1'b1, 1'b0, {WORD_W{1'b1}}})
	) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.pinIn({checkCharEnable_n, checkEnable, writeStrobe, writeData_n}),
		.level(pinLevel)
	);

	assign dataIn_n = pinLevel[WORD_W-1:0];
	assign strobeLevel = pinLevel[WORD_W];
	assign enableLevel = pinLevel[WORD_W+1];
	assign clearLevel_n = pinLevel[WORD_W+2];

	logic strobeLast;
	logic enableLast;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			strobeLast <= 1'b0;
			enableLast <= 1'b1;
		end else begin
			strobeLast <= strobeLevel;
			enableLast <= enableLevel;
		end
	end

	logic strobeRise;
	logic enableFall;
	logic enableRise;

	assign strobeRise = strobeLevel & ~strobeLast;
	assign enableFall = ~enableLevel & enableLast;
	assign enableRise = enableLevel & ~enableLast;

	////////////////////////////////////////////////////////////////////////
	// Control register

	logic nineChannel;
	logic softClear;
	logic apbWrite;
	logic apbRead;

	assign apbWrite = psel & penable & pready & pwrite;
	assign apbRead = psel & penable & ~pready & ~pwrite;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			nineChannel <= CTRL_NINE_RESET;
			softClear <= 1'b0;
		end else begin
			softClear <= 1'b0;
			if (apbWrite && paddr == CTRL_OFFSET[ADDR_W-1:0]) begin
				nineChannel <= pwdata[CTRL_NINE_BIT];
				softClear <= pwdata[CTRL_CLEAR_BIT];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Gap sequence

	tccg_gap_type gapState;
	logic [GDW-1:0] gapCount;
	logic gapPulse;
	logic gapPulseRise;
	logic gapPulseFall;

	assign gapPulse = (gapState == GAP_PULSE);

	// Falling check-enable starts the wait; rising one ends the wait or GAP_ROUTE, not GAP_PULSE
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gapState <= GAP_IDLE;
			gapCount <= '0;
		end else begin
			unique case (gapState)
				GAP_IDLE: begin
					if (enableFall && nineChannel) begin
						gapState <= GAP_DELAY;
						gapCount <= GDW'(GAP_DLY_CYC - 1);
					end
				end
				GAP_DELAY: begin
					if (enableRise) begin
						gapState <= GAP_IDLE;
					end else if (gapCount == '0) begin
						gapState <= GAP_PULSE;
						gapCount <= GDW'(GAP_PULSE_CYC - 1);
					end else begin
						gapCount <= gapCount - 1'b1;
					end
				end
				GAP_PULSE: begin
					if (gapCount == '0) begin
						gapState <= GAP_ROUTE;
					end else begin
						gapCount <= gapCount - 1'b1;
					end
				end
				GAP_ROUTE: begin
					if (enableRise) begin
						gapState <= GAP_IDLE;
					end
				end
			endcase
		end
	end

	assign gapPulseRise = (gapState == GAP_DELAY) && !enableRise
		&& gapCount == '0;
	assign gapPulseFall = gapPulse && gapCount == '0;

	// Routing follows the delayed check-enable
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			checkRouted <= 1'b0;
		end else begin
			checkRouted <= (gapState == GAP_PULSE || gapState == GAP_ROUTE)
				&& !enableRise;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Data gating and delayed shift

	logic [WORD_W-1:0] gatedData;
	logic [WORD_W-1:0] shiftData;
	logic [SDW-1:0] shiftCount;
	logic shiftArmed;
	logic shiftFire;
	logic strobeMerge;

	// Active-low pins become true data; the gap pulse blocks them
	assign gatedData = gapPulse ? '0 : ~dataIn_n;
	assign strobeMerge = strobeRise | gapPulseRise;

	// A strobe during a running delay restarts it with the new word
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shiftArmed <= 1'b0;
			shiftCount <= '0;
			shiftData <= '0;
		end else if (strobeMerge && nineChannel) begin
			shiftArmed <= 1'b1;
			shiftCount <= SDW'(STROBE_DLY_CYC - 1);
			shiftData <= gapPulseRise ? '0 : gatedData;
		end else if (shiftArmed) begin
			if (shiftCount == '0) begin
				shiftArmed <= 1'b0;
			end else begin
				shiftCount <= shiftCount - 1'b1;
			end
		end
	end

	assign shiftFire = shiftArmed && shiftCount == '0;

	////////////////////////////////////////////////////////////////////////
	// Check register

	logic [WORD_W-1:0] checkRegister;
	logic [WORD_W-1:0] firstStage;
	logic [WORD_W-1:0] toggleBit;

	for (genvar k = 0; k < WORD_W; k++) begin : gen_feedback
		localparam int ADJ = (k == 0) ? PARITY_IDX :
			(k == PARITY_IDX) ? FEEDBACK_TAP_IDX : k - 1;
		localparam bit THREE_WAY = (k >= 2) && (k <= 5);
		if (THREE_WAY) begin : gen_three
			assign firstStage[k] = shiftData[k] ^ checkRegister[ADJ]
				^ checkRegister[FEEDBACK_TAP_IDX];
		end else begin : gen_two
			assign firstStage[k] = shiftData[k] ^ checkRegister[ADJ];
		end
		assign toggleBit[k] = firstStage[k] ^ checkRegister[k];
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			checkRegister <= '0;
		end else if (!clearLevel_n || softClear) begin
			checkRegister <= '0;
		end else if (shiftFire) begin
			checkRegister <= checkRegister ^ toggleBit;
		end
	end

	logic [15:0] shiftTotal;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shiftTotal <= '0;
		end else if (!clearLevel_n || softClear) begin
			shiftTotal <= '0;
		end else if (shiftFire) begin
			shiftTotal <= shiftTotal + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output words and write-check pulse

	tccg_stream_if #(.WIDTH(WORD_W)) pushIf ();

	logic [WORD_W-1:0] checkWord_n;

	// Bits two and four leave non-inverted
	assign checkWord_n = ~(checkRegister ^ CHECK_TRUE_MASK);

	// One held word: a pin strobe during a stall is lost, so the
	// buffer is sized to cover the drain's usual answer time
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pushIf.valid <= 1'b0;
			pushIf.data <= '1;
		end else if (pushIf.valid && !pushIf.ready) begin
			pushIf.valid <= 1'b1;
		end else if (gapPulseFall) begin
			pushIf.valid <= 1'b1;
			pushIf.data <= checkWord_n;
		end else if (strobeRise && !checkRouted) begin
			pushIf.valid <= 1'b1;
			pushIf.data <= ~gatedData;
		end else begin
			pushIf.valid <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			write_check_pulse_n <= 1'b1;
		end else begin
			write_check_pulse_n <= !gapPulseFall;
		end
	end

	tccg_skid #(.WIDTH(WORD_W)) u_skid (
		.clk(clk),
		.rst_n(rst_n),
		.inPort(pushIf.sink),
		.outValid(bufValid),
		.outData(bufData_n),
		.outReady(bufReady)
	);

	////////////////////////////////////////////////////////////////////////
	// APB read path

	logic [31:0] readValue;
	logic addrHit;

	always_comb begin
		readValue = '0;
		addrHit = 1'b1;
		if (paddr == CTRL_OFFSET[ADDR_W-1:0]) begin
			readValue[CTRL_NINE_BIT] = nineChannel;
		end else if (paddr == STATUS_OFFSET[ADDR_W-1:0]) begin
			readValue[WORD_W-1:0] = checkRegister;
			readValue[STATUS_ROUTE_BIT] = checkRouted;
			readValue[STATUS_GAP_BIT] = gapPulse;
			readValue[STATUS_STALL_BIT] = pushIf.valid & ~pushIf.ready;
		end else if (paddr == COUNT_OFFSET[ADDR_W-1:0]) begin
			readValue[15:0] = shiftTotal;
		end else begin
			addrHit = 1'b0;
		end
	end

	// One wait state: pready rises in the second access cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~addrHit;
			// Unmapped or write accesses answer with zero read data
			prdata <= apbRead ? readValue : '0;
		end
	end

endmodule : tccg_top

/* tb/tccg_top_sva.sv */
/*
 * Port checker for tccg_top: bus answer, gap sequence, check routing.
 * Assumes pins pass the input synchronisers before acting.
 */
module tccg_top_sva
	import tccg_pkg::*;
#(
	parameter int GAP_DLY_CYC = 8,
	parameter int GAP_PULSE_CYC = 8
) (
	// Clock, reset and bus
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	// Pins
	input wire logic checkEnable,
	input wire logic bufValid,
	input wire logic [WORD_W-1:0] bufData_n,
	input wire logic bufReady,
	input wire logic write_check_pulse_n,
	input wire logic checkRouted
);
	timeunit 1ns;
	timeprecision 1ps;
	// Ranges allow for synchroniser latency of three to four edges
	localparam int RLO = GAP_DLY_CYC;
	localparam int RHI = GAP_DLY_CYC + 8;
	localparam int PLO = GAP_PULSE_CYC - 1;
	localparam int PHI = GAP_PULSE_CYC + 3;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	//////////////////////////////////////////
	property p_wait; psel && penable && !pready |=> pready; endproperty
	a_wait: assert property (p_wait) else $error("bus answer late");
	property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_gap; $fell(checkEnable) |-> ##[RLO:RHI] $rose(checkRouted);
	endproperty
	a_gap: assert property (p_gap) else $error("gap pulse missing");
	property p_end; $rose(checkRouted) |-> ##[PLO:PHI] !write_check_pulse_n;
	endproperty
	a_end: assert property (p_end) else $error("check pulse timing");
	property p_one; $fell(write_check_pulse_n) |=> write_check_pulse_n;
	endproperty
	a_one: assert property (p_one) else $error("check pulse width");
	property p_rt; !write_check_pulse_n |-> checkRouted; endproperty
	a_rt: assert property (p_rt) else $error("pulse while not routed");
	property p_hold; $rose(checkRouted) |=> checkRouted[*8]; endproperty
	a_hold: assert property (p_hold) else $error("route dropped");
	property p_push; $fell(write_check_pulse_n) |-> ##[0:4] bufValid;
	endproperty
	a_push: assert property (p_push) else $error("check word lost");
	property p_stall; bufValid && !bufReady |=> bufValid && $stable(bufData_n);
	endproperty
	a_stall: assert property (p_stall) else $error("word changed");
	property p_fall; $fell(checkRouted) |-> $past(checkEnable, 3); endproperty
	a_fall: assert property (p_fall) else $error("route ended early");
	c_pulse: cover property ($fell(write_check_pulse_n));
	c_stall: cover property (bufValid && !bufReady);
	c_err: cover property (pslverr);
endmodule : tccg_top_sva

bind tccg_top tccg_top_sva #(.GAP_DLY_CYC(GAP_DLY_CYC),
	.GAP_PULSE_CYC(GAP_PULSE_CYC)) chk_u (.clk(clk), .rst_n(rst_n),
	.psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
	.prdata(prdata), .checkEnable(checkEnable), .bufValid(bufValid),
	.bufData_n(bufData_n), .bufReady(bufReady),
	.write_check_pulse_n(write_check_pulse_n), .checkRouted(checkRouted));

/* tb/tccg_buf_model.sv */
/*
 * Write buffer on the far side: takes words, may stall, counts pulses.
 * Assumes one clock with the generator.
 */
module tccg_buf_model
	import tccg_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Word stream and check pulse
	input wire logic stall,
	input wire logic bufValid,
	input wire logic [WORD_W-1:0] bufData_n,
	output logic bufReady,
	input wire logic write_check_pulse_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [WORD_W-1:0] got[$];
	int checkPulses = 0;
	// Stall is the only way the model refuses a word
	assign bufReady = !stall;
	always @(posedge clk) begin
		if (rst_n && bufValid && bufReady) begin
			got.push_back(bufData_n);
		end
		if (rst_n && !write_check_pulse_n) begin
			checkPulses++;
		end
	end
endmodule : tccg_buf_model

/* tb/test_tccg_top.sv */
/*
 * Self-checking bench for tccg_top with short delay counts.
 * Assumes the buffer model as far side and APB from this module.
 */
module test_tccg_top
	import tccg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SD = 4;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, bufValid, bufReady, wcpN, checkRouted;
	logic [WORD_W-1:0] writeData_n = 9'h1ff, bufData_n, crc = 9'h000;
	logic strobe = 1'b0, checkEnable = 1'b1, clr_n = 1'b1, stall = 1'b0;
	int errorCnt = 0, checked = 0;
	always #5 clk = ~clk;
	tccg_top #(.STROBE_DLY_CYC(SD), .GAP_DLY_CYC(8), .GAP_PULSE_CYC(8),
		.ADDR_W(8)) dut_u (.clk(clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.writeData_n(writeData_n), .writeStrobe(strobe),
		.checkEnable(checkEnable), .checkCharEnable_n(clr_n),
		.bufValid(bufValid), .bufData_n(bufData_n), .bufReady(bufReady),
		.write_check_pulse_n(wcpN), .checkRouted(checkRouted));
	tccg_buf_model partner_u (.clk(clk), .rst_n(rst_n), .stall(stall),
		.bufValid(bufValid), .bufData_n(bufData_n), .bufReady(bufReady),
		.write_check_pulse_n(wcpN));
	//////////////////////////////////////////
	task automatic stop_test();
		$display("Compared %0d, mismatched %0d", checked, errorCnt);
		if (errorCnt == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : stop_test
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errorCnt++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (n > 20) begin
				errorCnt++;
				stop_test();
			end
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	// Expected register: each bit takes the data bit xor its neighbour, and bits 2 to 5 also xor bit 7
	function automatic logic [8:0] step(input logic [8:0] r,
		input logic [8:0] d);
		logic [8:0] f;
		f[0] = d[0] ^ r[8];
		for (int k = 1; k < 8; k++) begin
			f[k] = d[k] ^ r[k-1] ^ (k >= 2 && k <= 5 ? r[7] : 1'b0);
		end
		f[8] = d[8] ^ r[7];
		return f;
	endfunction : step
	task automatic send(input logic [8:0] dn, input logic nine);
		writeData_n <= dn;
		strobe <= 1'b1;
		repeat (4) @(posedge clk);
		strobe <= 1'b0;
		repeat (SD + 12) @(posedge clk);
		if (nine) crc = step(crc, ~dn);
	endtask : send
	task automatic take(input logic [8:0] exp);
		check({23'h0, partner_u.got.pop_front()}, {23'h0, exp});
	endtask : take
	task automatic status();
		apb(1'b0, STATUS_OFFSET, 32'h0);
		check({23'h0, rd[8:0]}, {23'h0, crc});
	endtask : status
	//////////////////////////////////////////
	task automatic t_regs();
		apb(1'b0, CTRL_OFFSET, 32'h0);
		check(rd, 32'h1);
		apb(1'b1, STATUS_OFFSET, 32'hffffffff);
		status();
		apb(1'b0, 8'h0c, 32'h0);
		check({31'h0, err}, 32'h1);
		check(rd, 32'h0);
	endtask : t_regs
	task automatic t_data();
		logic [8:0] tbl[5] = '{9'h1ff, 9'h000, 9'h0aa, 9'h155, 9'h0f0};
		foreach (tbl[i]) begin
			send(tbl[i], 1'b1);
			take(tbl[i]);
			status();
		end
		apb(1'b0, COUNT_OFFSET, 32'h0);
		check({16'h0, rd[15:0]}, 32'h5);
	endtask : t_data
	task automatic t_gap();
		int n;
		n = 0;
		writeData_n <= 9'h000;
		checkEnable <= 1'b0;
		while (wcpN !== 1'b0) begin
			@(posedge clk);
			n++;
			if (n > 60) begin
				errorCnt++;
				stop_test();
			end
		end
		check({31'h0, checkRouted}, 32'h1);
		crc = step(crc, 9'h000);
		repeat (6) @(posedge clk);
		take(~(crc ^ CHECK_TRUE_MASK));
		apb(1'b0, STATUS_OFFSET, 32'h0);
		check({22'h0, rd[9:0]}, {23'h1, crc});
		check(32'(partner_u.checkPulses), 32'h1);
		checkEnable <= 1'b1;
		writeData_n <= 9'h1ff;
		repeat (10) @(posedge clk);
		check({31'h0, checkRouted}, 32'h0);
		clr_n <= 1'b0;
		repeat (8) @(posedge clk);
		clr_n <= 1'b1;
		repeat (6) @(posedge clk);
		crc = 9'h000;
		status();
	endtask : t_gap
	task automatic t_stall();
		stall <= 1'b1;
		send(9'h011, 1'b1);
		send(9'h122, 1'b1);
		check({31'h0, bufValid}, 32'h1);
		check(32'(partner_u.got.size()), 32'h0);
		stall <= 1'b0;
		repeat (6) @(posedge clk);
		take(9'h011);
		take(9'h122);
		status();
	endtask : t_stall
	task automatic t_seven();
		apb(1'b1, CTRL_OFFSET, 32'h0);
		send(9'h0aa, 1'b0);
		take(9'h0aa);
		status();
		apb(1'b1, CTRL_OFFSET, 32'h3);
		apb(1'b0, CTRL_OFFSET, 32'h0);
		check(rd, 32'h1);
		crc = 9'h000;
		status();
	endtask : t_seven
	// Mid-run reset: idle outputs, control back to nine-channel, clear
	task automatic t_reset();
		send(9'h0f0, 1'b1);
		take(9'h0f0);
		apb(1'b1, CTRL_OFFSET, 32'h0);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		check({28'h0, bufValid, wcpN, checkRouted, pready}, 32'h4);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
		apb(1'b0, CTRL_OFFSET, 32'h0);
		check(rd, 32'h1);
		crc = 9'h000;
		status();
	endtask : t_reset
	//////////////////////////////////////////
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
		t_regs();
		t_data();
		t_gap();
		t_stall();
		t_seven();
		t_reset();
		stop_test();
	end
endmodule : test_tccg_top
